// ==== src/shadow_alias.sv ====
// Notes on behaviour
// RQ1 - Read returns latest received byte, line or infrared
// RQ2 - Received data valid only while data-ready set
// RQ3 - No queue: new byte overwrites, flags overrun
// RQ4 - Queue on: read returns oldest queued byte
// RQ5 - Full receive queue: drop new byte, overrun
// RQ6 - Write supplies byte for line or infrared output
// RQ7 - Software writes only while holding-empty is set
// RQ8 - No queue: one write clears holding-empty
// RQ9 - No queue: later write replaces waiting byte
// RQ10 - Queue on: accept writes up to depth
// RQ11 - Write to full transmit queue is discarded
// RQ12 - Sixteen word aliases reach same buffers
// RQ13 - Bits 15:8 read zero; data resets zero
// RQ14 - Queue on: read pops head, clears ready only when queue empties
module shadow_alias #(
    parameter int DEPTH = shadow_alias_pkg::QUEUE_DEPTH
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_BYTE,
    input wire logic TX_TAKE,
    output logic TX_VALID,
    output logic [7:0] TX_BYTE,
    output logic IR_MODE,
    output logic IRQ
);
    localparam int AW = $clog2(DEPTH);
    // ========================================
    // Address decode
    logic hit_alias, hit_ctrl, hit_stat, hit_ist, hit_imask, hit_hold;
    logic alias_rd, alias_wr;

    always_comb begin
        hit_alias = 1'b0;
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        hit_ist = 1'b0;
        hit_imask = 1'b0;
        hit_hold = 1'b0;
        if (ADDR[1:0] != 2'h0) begin
            hit_alias = 1'b0;
        end else if (ADDR >= shadow_alias_pkg::ALIAS_BASE && ADDR < shadow_alias_pkg::ALIAS_BASE
                     + shadow_alias_pkg::ALIAS_SPAN) begin
            hit_alias = 1'b1; // see RQ12
        end else if (ADDR == shadow_alias_pkg::CTRL_ADDR) begin
            hit_ctrl = 1'b1;
        end else if (ADDR == shadow_alias_pkg::STAT_ADDR) begin
            hit_stat = 1'b1;
        end else if (ADDR == shadow_alias_pkg::INT_STAT_ADDR) begin
            hit_ist = 1'b1;
        end else if (ADDR == shadow_alias_pkg::INT_MASK_ADDR) begin
            hit_imask = 1'b1;
        end else if (ADDR == shadow_alias_pkg::RX_HOLD_ADDR) begin
            hit_hold = 1'b1;
        end
    end

    assign alias_rd = RD && hit_alias;
    assign alias_wr = WR && hit_alias;

    // ========================================
    // Control register
    logic queue_en_ff, nxt_queue_en;
    logic ir_ff, nxt_ir;
    logic flush;

    always_comb begin
        nxt_queue_en = queue_en_ff;
        nxt_ir = ir_ff;
        if (WR && hit_ctrl) begin
            nxt_queue_en = WDATA[shadow_alias_pkg::CTRL_QUEUE_EN];
            nxt_ir = WDATA[shadow_alias_pkg::CTRL_IR_MODE];
        end
    end
    // Switching queue mode empties both queues, as the holding slot is reused
    assign flush = queue_en_ff != nxt_queue_en;

    // ========================================
    // Receive path
    logic [7:0] rx_hold_ff, nxt_rx_hold;
    logic ready_ff, nxt_ready;
    logic ovr_ff, nxt_ovr;
    logic rxq_push, rxq_empty, rxq_full;
    logic [7:0] rxq_head;
    logic [AW:0] rxq_cnt;
    logic rxq_next_empty;
    logic rx_lost;

    byte_queue #(.DEPTH(DEPTH), .W(shadow_alias_pkg::DATA_W)) rx_queue (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .flush(flush),
        .push(rxq_push),
        .push_data(RX_BYTE),
        .pop(alias_rd && queue_en_ff), // see RQ14
        .head(rxq_head),
        .empty(rxq_empty),
        .full(rxq_full),
        .count(rxq_cnt),
        .next_empty(rxq_next_empty),
        .next_head()
    );

    always_comb begin
        rxq_push = RX_VALID && queue_en_ff;
        nxt_rx_hold = rx_hold_ff;
        nxt_ready = ready_ff;
        rx_lost = 1'b0;
        if (queue_en_ff) begin
            rx_lost = RX_VALID && rxq_full && !alias_rd; // see RQ5
            // Ready follows queue occupancy after this cycle's push and pop
            nxt_ready = !rxq_next_empty; // see RQ14
        end else begin
            if (alias_rd) begin
                nxt_ready = 1'b0;
            end
            if (RX_VALID) begin
                rx_lost = ready_ff && !alias_rd; // see RQ3
                nxt_rx_hold = RX_BYTE; // see RQ1
                nxt_ready = 1'b1;
            end
        end
        if (flush) begin
            nxt_ready = 1'b0;
        end
        // Overrun stays until the status register is read; a new loss wins
        nxt_ovr = rx_lost || (ovr_ff && !(RD && hit_stat));
    end

    // ========================================
    // Transmit path
    logic [7:0] tx_hold_ff, nxt_tx_hold;
    logic hold_empty_ff, nxt_hold_empty;
    logic txq_push, txq_pop, txq_empty, txq_full;
    logic [7:0] txq_head;
    logic txq_next_empty;
    logic [7:0] txq_next_head;
    logic tx_drop;
    logic tx_valid_ff, nxt_tx_valid;
    logic [7:0] tx_byte_ff, nxt_tx_byte;

    byte_queue #(.DEPTH(DEPTH), .W(shadow_alias_pkg::DATA_W)) tx_queue (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .flush(flush),
        .push(txq_push),
        .push_data(WDATA[7:0]),
        .pop(txq_pop),
        .head(txq_head),
        .empty(txq_empty),
        .full(txq_full),
        .count(),
        .next_empty(txq_next_empty),
        .next_head(txq_next_head)
    );

    always_comb begin
        txq_push = alias_wr && queue_en_ff; // see RQ10
        txq_pop = queue_en_ff && TX_TAKE && !txq_empty;
        // A take in the same cycle frees the slot, so only then is a write to a full queue kept
        tx_drop = alias_wr && queue_en_ff && txq_full && !txq_pop; // see RQ11
        nxt_tx_hold = tx_hold_ff;
        nxt_hold_empty = hold_empty_ff;
        if (queue_en_ff) begin
            // Valid must drop with the last pop, or the line would take a stale byte
            nxt_hold_empty = txq_next_empty; // see RQ10
        end else begin
            if (TX_TAKE && !hold_empty_ff) begin
                nxt_hold_empty = 1'b1;
            end
            if (alias_wr) begin
                nxt_tx_hold = WDATA[7:0]; // see RQ6, RQ9
                nxt_hold_empty = 1'b0; // see RQ8
            end
        end
        if (flush) begin
            nxt_hold_empty = 1'b1;
        end
        nxt_tx_valid = !nxt_hold_empty;
        nxt_tx_byte = nxt_queue_en ? txq_next_head : nxt_tx_hold;
    end

    // ========================================
    // Interrupts
    logic [2:0] ist_ff, nxt_ist;
    logic [2:0] imask_ff, nxt_imask;
    logic [2:0] events;
    logic irq_ff, nxt_irq;

    always_comb begin
        events = 3'h0;
        events[shadow_alias_pkg::INT_RX] = nxt_ready && !ready_ff;
        events[shadow_alias_pkg::INT_OVERRUN] = rx_lost;
        events[shadow_alias_pkg::INT_TX_DROP] = tx_drop;
        // Read clears, but an event in the same cycle is kept
        nxt_ist = ((RD && hit_ist) ? 3'h0 : ist_ff) | events;
        nxt_imask = (WR && hit_imask) ? WDATA[2:0] : imask_ff;
        nxt_irq = |(nxt_ist & nxt_imask);
    end

    // ========================================
    // Read data
    logic [31:0] rdata_ff, nxt_rdata;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (RD) begin
            if (hit_alias) begin
                // Upper bits stay zero; stale data is shown but only valid with ready.
                // An empty queue reads zero, as its storage has no reset.
                nxt_rdata[7:0] = queue_en_ff ? (rxq_empty ? 8'h00 : rxq_head)
                                             : rx_hold_ff; // see RQ4, RQ13, RQ2
            end else if (hit_ctrl) begin
                nxt_rdata[shadow_alias_pkg::CTRL_QUEUE_EN] = queue_en_ff;
                nxt_rdata[shadow_alias_pkg::CTRL_IR_MODE] = ir_ff;
            end else if (hit_stat) begin
                nxt_rdata[shadow_alias_pkg::STAT_DATA_READY] = ready_ff; // see RQ2
                nxt_rdata[shadow_alias_pkg::STAT_OVERRUN] = ovr_ff;
                nxt_rdata[shadow_alias_pkg::STAT_HOLD_EMPTY] = hold_empty_ff; // see RQ7
            end else if (hit_ist) begin
                nxt_rdata[2:0] = ist_ff;
            end else if (hit_imask) begin
                nxt_rdata[2:0] = imask_ff;
            end else if (hit_hold) begin
                nxt_rdata[7:0] = tx_hold_ff;
            end
        end
    end

    // ========================================
    // State registers
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            queue_en_ff <= 1'b0;
            ir_ff <= 1'b0;
            rx_hold_ff <= shadow_alias_pkg::DATA_RESET; // see RQ13
            ready_ff <= 1'b0;
            ovr_ff <= 1'b0;
            tx_hold_ff <= shadow_alias_pkg::DATA_RESET;
            hold_empty_ff <= 1'b1;
            tx_valid_ff <= 1'b0;
            tx_byte_ff <= shadow_alias_pkg::DATA_RESET;
            ist_ff <= 3'h0;
            imask_ff <= shadow_alias_pkg::MASK_RESET;
            irq_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            queue_en_ff <= nxt_queue_en;
            ir_ff <= nxt_ir;
            rx_hold_ff <= nxt_rx_hold;
            ready_ff <= nxt_ready;
            ovr_ff <= nxt_ovr;
            tx_hold_ff <= nxt_tx_hold;
            hold_empty_ff <= nxt_hold_empty;
            tx_valid_ff <= nxt_tx_valid;
            tx_byte_ff <= nxt_tx_byte;
            ist_ff <= nxt_ist;
            imask_ff <= nxt_imask;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;
    assign TX_VALID = tx_valid_ff;
    assign TX_BYTE = tx_byte_ff;
    assign IR_MODE = ir_ff;
    assign IRQ = irq_ff;

    // ========================================
    // Checks
    overrun_flag_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ3
        !queue_en_ff && RX_VALID && ready_ff && !alias_rd && !flush && !(RD && hit_stat)
        |=> ovr_ff)
        else $error("overrun not flagged on overwrite");

    rx_latest_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ1
        !queue_en_ff && RX_VALID && !flush |=> rx_hold_ff == $past(RX_BYTE) && ready_ff)
        else $error("received byte not held");

    alias_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ4
        RD && hit_alias && queue_en_ff
        |=> RDATA[31:8] == 24'h0 && RDATA[7:0] == ($past(rxq_empty) ? 8'h00 : $past(rxq_head)))
        else $error("alias read not queue head");

    upper_zero_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ13
        $past(alias_rd) |-> RDATA[31:8] == 24'h0)
        else $error("reserved alias bits not zero");

    hold_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ8
        !queue_en_ff && !flush && alias_wr |=> !hold_empty_ff ##0 TX_VALID)
        else $error("holding-empty not cleared by write");

    hold_replace_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ9
        !queue_en_ff && !flush && alias_wr |=> tx_hold_ff == $past(WDATA[7:0]))
        else $error("holding byte not replaced");

    tx_drop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ11
        tx_drop && !flush |=> ist_ff[shadow_alias_pkg::INT_TX_DROP] && txq_full)
        else $error("full queue write not discarded");

    rx_loss_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ5
        queue_en_ff && RX_VALID && rxq_full && !alias_rd && !flush
        |=> rxq_full && rxq_head == $past(rxq_head) && ovr_ff)
        else $error("full receive queue altered");

    ready_drop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ14
        queue_en_ff && alias_rd && rxq_cnt == (AW+1)'(1) && !RX_VALID |=> !ready_ff)
        else $error("ready not cleared on empty queue");

    rx_ready_level_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ14
        queue_en_ff |-> ready_ff == !rxq_empty)
        else $error("ready does not match receive queue");

    rx_read_keep_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ5
        queue_en_ff && RX_VALID && rxq_full && alias_rd && !flush |=> rxq_full && ready_ff)
        else $error("byte lost although head was read");

    tx_accept_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ10
        queue_en_ff && alias_wr && !txq_full && !flush |=> !txq_empty && TX_VALID)
        else $error("queued write not offered to line");

    tx_head_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ10
        queue_en_ff && !txq_empty |-> TX_VALID && TX_BYTE == txq_head)
        else $error("line byte not queue head");

    tx_take_empty_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ8
        !queue_en_ff && !flush && TX_TAKE && !hold_empty_ff && !alias_wr
        |=> hold_empty_ff && !TX_VALID)
        else $error("holding-empty not set after take");

    ir_mode_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see RQ6
        WR && hit_ctrl |=> IR_MODE == $past(WDATA[shadow_alias_pkg::CTRL_IR_MODE]))
        else $error("infrared mode not taken from control");

    rdata_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !RD |=> RDATA == 32'h0000_0000)
        else $error("read data not zero outside a read");

    irq_level_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        IRQ == |(ist_ff & imask_ff))
        else $error("interrupt line does not match status");
endmodule

// ==== pkg/shadow_alias_pkg.sv ====
package shadow_alias_pkg;
    // ========================================
    // Register map (byte addresses)
    localparam logic [31:0] ALIAS_BASE = 32'h5000_1030;
    localparam logic [31:0] ALIAS_TWO = 32'h5000_1038;
    localparam logic [31:0] ALIAS_THREE = 32'h5000_103C;
    localparam int ALIAS_COUNT = 16;
    localparam logic [31:0] ALIAS_SPAN = 32'h0000_0040;
    localparam logic [31:0] CTRL_ADDR = 32'h5000_1100;
    localparam logic [31:0] STAT_ADDR = 32'h5000_1104;
    localparam logic [31:0] INT_STAT_ADDR = 32'h5000_1108;
    localparam logic [31:0] INT_MASK_ADDR = 32'h5000_110C;
    localparam logic [31:0] RX_HOLD_ADDR = 32'h5000_1110;
    // ========================================
    // Field positions
    localparam int CTRL_QUEUE_EN = 0;
    localparam int CTRL_IR_MODE = 1;
    localparam int STAT_DATA_READY = 0;
    localparam int STAT_OVERRUN = 1;
    localparam int STAT_HOLD_EMPTY = 5;
    localparam int INT_RX = 0;
    localparam int INT_OVERRUN = 1;
    localparam int INT_TX_DROP = 2;
    localparam int INT_BITS = 3;
    // ========================================
    // Reset values and sizes
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam int QUEUE_DEPTH = 16;
    localparam int DATA_W = 8;
endpackage

// ==== src/byte_queue.sv ====
module byte_queue #(
    parameter int DEPTH = shadow_alias_pkg::QUEUE_DEPTH,
    parameter int W = shadow_alias_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push,
    input wire logic [W-1:0] push_data,
    input wire logic pop,
    output logic [W-1:0] head,
    output logic empty,
    output logic full,
    output logic [$clog2(DEPTH):0] count,
    output logic next_empty,
    output logic [W-1:0] next_head
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] rd_ff, wr_ff, nxt_rd, nxt_wr;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic do_push, do_pop;

    assign empty = (cnt_ff == '0);
    assign full = (cnt_ff == (AW+1)'(DEPTH));
    assign head = mem[rd_ff];
    assign count = cnt_ff;

    always_comb begin
        // Push into a full queue is dropped unless a pop frees a slot in the same cycle
        do_pop = pop && !empty;
        do_push = push && (!full || do_pop);
        nxt_rd = rd_ff;
        nxt_wr = wr_ff;
        nxt_cnt = cnt_ff;
        if (flush) begin
            nxt_rd = '0;
            nxt_wr = '0;
            nxt_cnt = '0;
        end else begin
            if (do_push) begin
                nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
            end
            if (do_pop) begin
                nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
            end
            nxt_cnt = cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // Head as it will stand after this edge; the pushed byte when the queue drains
    assign next_empty = (nxt_cnt == '0);
    assign next_head = (cnt_ff == (AW+1)'(do_pop)) ? push_data : mem[nxt_rd];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ff <= '0;
            wr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage has no reset so it maps onto plain RAM
    always_ff @(posedge clk) begin
        if (do_push && !flush) begin
            mem[wr_ff] <= push_data;
        end
    end
endmodule

// ==== verif/line_partner.sv ====
module line_partner (
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic stall,
    output logic tx_take,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    initial begin
        tx_take = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // ========================================
    // Receive side: idle data shows the inverse of the last byte, never a stale copy
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_byte <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
    // ========================================
    // Transmit side: stall models a slow line; a gap follows each take
    always @(posedge clk) begin
        if (tx_take) begin
            tx_take <= 1'b0;
        end else if (tx_valid && !stall) begin
            tx_take <= 1'b1;
            got.push_back(tx_byte);
        end
    end
endmodule

// ==== verif/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = 4;
    logic clk, rst_n, wr_s, rd_s, stall;
    logic [31:0] addr, wdata, rdata, q;
    logic tx_take, tx_valid, rx_valid, ir_mode, irq;
    logic [7:0] tx_byte, rx_byte, b;
    logic [7:0] exp_q[$];
    int errors, cmp_count, seed;

    shadow_alias #(.DEPTH(D)) dut (
        .REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
        .TX_TAKE(tx_take), .TX_VALID(tx_valid), .TX_BYTE(tx_byte),
        .IR_MODE(ir_mode), .IRQ(irq)
    );
    line_partner u_line (
        .clk(clk), .tx_valid(tx_valid), .tx_byte(tx_byte), .stall(stall),
        .tx_take(tx_take), .rx_valid(rx_valid), .rx_byte(rx_byte)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ========================================
    // Bus tasks and expectations
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] alias_at(input int i);
        return shadow_alias_pkg::ALIAS_BASE + 32'(4 * i);
    endfunction
    function automatic logic [31:0] stat_exp(input logic rdy, input logic ovr, input logic emp);
        return {26'h0, emp, 3'h0, ovr, rdy};
    endfunction
    task automatic stop_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ========================================
    // Main sequence
    initial begin
        seed = 50051;
        errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        stall = 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(shadow_alias_pkg::ALIAS_TWO, q);
        chk("alias reset", 32'h0, q);
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("stat reset", stat_exp(0, 0, 1), q);
        // Every alias returns the latest byte, upper bits zero
        for (int i = 0; i < 16; i++) begin
            b = 8'($random(seed));
            u_line.send(b);
            rd(shadow_alias_pkg::STAT_ADDR, q);
            chk("ready", stat_exp(1, 0, 1), q);
            rd(alias_at(i), q);
            chk("rx alias", {24'h0, b}, q);
        end
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("ready clear", stat_exp(0, 0, 1), q);
        u_line.send(8'h11);
        b = 8'($random(seed));
        u_line.send(b);
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("overrun", stat_exp(1, 1, 1), q);
        rd(alias_at(15), q);
        chk("overwrite", {24'h0, b}, q);
        // Holding register with the line stalled: a second write replaces the first
        wr(shadow_alias_pkg::ALIAS_TWO, 32'h0000_AB5A);
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("hold full", stat_exp(0, 0, 0), q);
        chk("tx byte", 32'h5A, {24'h0, tx_byte});
        chk("tx valid", 32'h1, {31'h0, tx_valid});
        wr(shadow_alias_pkg::ALIAS_THREE, 32'h0000_003C);
        stall <= 1'b0;
        for (int k = 0; k < 50 && u_line.got.size() < 1; k++) @(posedge clk);
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("hold empty", stat_exp(0, 0, 1), q);
        chk("tx count", 32'h1, 32'(u_line.got.size()));
        chk("tx replace", 32'h3C, {24'h0, u_line.got[0]});
        // Queues and infrared on; receive past the depth
        wr(shadow_alias_pkg::CTRL_ADDR, 32'h0000_0003);
        exp_q.delete();
        for (int i = 0; i <= D; i++) begin
            b = 8'($random(seed));
            u_line.send(b);
            if (i < D) exp_q.push_back(b);
        end
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("ir mode", 32'h1, {31'h0, ir_mode});
        chk("rx full", stat_exp(1, 1, 1), q);
        for (int i = 0; i < D; i++) begin
            rd(alias_at(4 * i + 2), q);
            chk("rx head", {24'h0, exp_q[i]}, q);
        end
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("rx drained", stat_exp(0, 0, 1), q);
        // Transmit queue past the depth; only the dropped write is unmasked
        wr(shadow_alias_pkg::INT_MASK_ADDR, 32'h0000_0004);
        stall <= 1'b1;
        u_line.got.delete();
        exp_q.delete();
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("irq masked", 32'h0, {31'h0, irq});
        for (int i = 0; i <= D; i++) begin
            b = 8'($random(seed));
            wr(alias_at(15 - i), {24'h0, b});
            if (i < D) exp_q.push_back(b);
        end
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("irq raised", 32'h1, {31'h0, irq});
        rd(shadow_alias_pkg::INT_STAT_ADDR, q);
        chk("drop flag", 32'h4, q & 32'h4);
        rd(shadow_alias_pkg::STAT_ADDR, q);
        chk("irq clear", 32'h0, {31'h0, irq});
        stall <= 1'b0;
        for (int k = 0; k < 200 && u_line.got.size() < D; k++) @(posedge clk);
        repeat (8) @(posedge clk);
        chk("tx count q", 32'(D), 32'(u_line.got.size()));
        chk("tx idle", 32'h0, {31'h0, tx_valid});
        for (int i = 0; i < D; i++) begin
            chk("tx order", {24'h0, exp_q[i]}, {24'h0, u_line.got[i]});
        end
        rd(32'h5000_1070, q);
        chk("unmapped", 32'h0, q);
        stop_test();
    end
    // A hang is cut short well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test();
    end
endmodule
